// ---- hdl/fifo_host.sv ----
/*
 Controller that writes words into and reads words out of one fall-through FIFO
 slice through its pins, in serial or parallel form chosen per word.
 Assumes the slice is used alone as a row master and that its outputs arrive
 asynchronously; all of them are synchronised before use.
*/
`timescale 1ns/100ps
`default_nettype none
module fifo_host (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic wr_valid,
  input wire fifo_host_pkg::word_t wr_data,
  input wire logic wr_serial,
  output wire logic wr_ready,
  input wire logic rd_serial,
  input wire logic rd_ready,
  output wire logic rd_valid,
  output wire fifo_host_pkg::word_t rd_data,
  input wire fifo_host_pkg::sense_s pins_in,
  output wire fifo_host_pkg::drive_s pins_out
);
  typedef struct packed {
    fifo_host_pkg::in_st_e in_st;
    fifo_host_pkg::out_st_e out_st;
    fifo_host_pkg::cnt_t cnt_in;
    fifo_host_pkg::cnt_t cnt_out;
    fifo_host_pkg::bit_idx_t bit_in;
    fifo_host_pkg::bit_idx_t bit_out;
    fifo_host_pkg::word_t word_in;
    logic rd_ser;
    logic wr_ready;
    logic rd_valid;
    fifo_host_pkg::word_t rd_data;
    fifo_host_pkg::drive_s drv;
  } state_s;

  state_s q;
  state_s d;
  fifo_host_pkg::sense_s s;

  // The slice has no clock of ours, so every pin it drives is resynchronised.
  sync2 #(
    .W(fifo_host_pkg::SENSE_W)
  ) sync2_inst (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .d(pins_in),
    .q(s)
  );

  // Counters stop at zero so an idle state never wraps round to a long wait.
  function automatic fifo_host_pkg::cnt_t count_down(input fifo_host_pkg::cnt_t c);
    if (c == fifo_host_pkg::CNT_ZERO) begin
      return c;
    end
    return c - fifo_host_pkg::CNT_ONE;
  endfunction : count_down

  function automatic fifo_host_pkg::bit_idx_t next_bit(input fifo_host_pkg::bit_idx_t b);
    return b + fifo_host_pkg::BIT_STEP;
  endfunction : next_bit

  always_comb begin
    d = q;
    d.cnt_in = count_down(q.cnt_in);
    d.cnt_out = count_down(q.cnt_out);
    if (q.rd_valid && rd_ready) begin
      d.rd_valid = 1'h0;
    end

    case (q.in_st)
      fifo_host_pkg::IN_CLEAR: begin
        if (q.cnt_in == fifo_host_pkg::CNT_ZERO) begin
          d.drv.clear_n = 1'h1;
          d.wr_ready = 1'h1;
          d.in_st = fifo_host_pkg::IN_IDLE;
        end
      end
      fifo_host_pkg::IN_IDLE: begin
        if (wr_valid) begin
          d.wr_ready = 1'h0;
          d.word_in = wr_data;
          d.cnt_in = fifo_host_pkg::PULSE_CYC;
          if (wr_serial) begin
            // Parallel load is left low for the whole serial entry.
            d.bit_in = fifo_host_pkg::FIRST_BIT;
            d.drv.ser_in_bit = wr_data[0];
            d.drv.ser_in_clk_n = 1'h1;
            d.in_st = fifo_host_pkg::IN_SHIFT_HI;
          end else begin
            // Serial input clock is already low here.
            d.drv.par_in_bits = wr_data;
            d.drv.parallel_load = 1'h1;
            d.in_st = fifo_host_pkg::IN_PLOAD;
          end
        end
      end
      fifo_host_pkg::IN_PLOAD: begin
        if (q.cnt_in == fifo_host_pkg::CNT_ZERO && !s.in_full_n) begin
          d.drv.parallel_load = 1'h0;
          d.in_st = fifo_host_pkg::IN_PUSH;
        end
      end
      fifo_host_pkg::IN_SHIFT_HI: begin
        if (q.cnt_in == fifo_host_pkg::CNT_ZERO) begin
          d.drv.ser_in_clk_n = 1'h0;
          d.cnt_in = fifo_host_pkg::PULSE_CYC;
          d.in_st = fifo_host_pkg::IN_SHIFT_LO;
        end
      end
      fifo_host_pkg::IN_SHIFT_LO: begin
        if (q.cnt_in == fifo_host_pkg::CNT_ZERO) begin
          if (q.bit_in == fifo_host_pkg::LAST_BIT) begin
            d.in_st = fifo_host_pkg::IN_PUSH;
          end else begin
            d.bit_in = next_bit(q.bit_in);
            d.drv.ser_in_bit = q.word_in[next_bit(q.bit_in)];
            d.drv.ser_in_clk_n = 1'h1;
            d.cnt_in = fifo_host_pkg::PULSE_CYC;
            d.in_st = fifo_host_pkg::IN_SHIFT_HI;
          end
        end
      end
      fifo_host_pkg::IN_PUSH: begin
        // Push is asked only once input-full is seen, and held until it clears.
        if (q.drv.push_stack_n) begin
          if (!s.in_full_n) begin
            d.drv.push_stack_n = 1'h0;
          end
        end else if (s.in_full_n) begin
          d.drv.push_stack_n = 1'h1;
          d.wr_ready = 1'h1;
          d.in_st = fifo_host_pkg::IN_IDLE;
        end
      end
      default: d.in_st = fifo_host_pkg::IN_CLEAR;
    endcase

    case (q.out_st)
      fifo_host_pkg::OUT_WAIT: begin
        // A read word is held until taken; the slice's register waits meanwhile.
        if (q.in_st != fifo_host_pkg::IN_CLEAR && !q.rd_valid) begin
          d.rd_ser = rd_serial;
          d.drv.pop_parallel = 1'h1;
          d.drv.pop_serial_n = 1'h0;
          d.drv.par_out_drive_n = rd_serial;
          d.bit_out = fifo_host_pkg::FIRST_BIT;
          d.out_st = fifo_host_pkg::OUT_REQ;
        end
      end
      fifo_host_pkg::OUT_REQ: begin
        if (s.out_empty_n) begin
          d.cnt_out = fifo_host_pkg::PULSE_CYC;
          d.out_st = fifo_host_pkg::OUT_SETTLE;
        end
      end
      fifo_host_pkg::OUT_SETTLE: begin
        if (q.cnt_out == fifo_host_pkg::CNT_ZERO) begin
          d.cnt_out = fifo_host_pkg::PULSE_CYC;
          if (!q.rd_ser) begin
            d.rd_data = s.par_out_bits;
            d.drv.pop_parallel = 1'h0;
            d.out_st = fifo_host_pkg::OUT_DROP;
          end else begin
            // Stop asking for a word so none reloads mid-shift.
            d.rd_data[q.bit_out] = s.ser_out_bit;
            d.drv.pop_serial_n = 1'h1;
            d.drv.ser_out_clk_n = 1'h1;
            d.out_st = fifo_host_pkg::OUT_SCLK_HI;
          end
        end
      end
      fifo_host_pkg::OUT_SCLK_HI: begin
        if (q.cnt_out == fifo_host_pkg::CNT_ZERO) begin
          d.drv.ser_out_clk_n = 1'h0;
          d.cnt_out = fifo_host_pkg::PULSE_CYC;
          d.out_st = fifo_host_pkg::OUT_SCLK_LO;
        end
      end
      fifo_host_pkg::OUT_SCLK_LO: begin
        if (q.cnt_out == fifo_host_pkg::CNT_ZERO) begin
          if (q.bit_out == fifo_host_pkg::LAST_BIT) begin
            d.drv.pop_parallel = 1'h0;
            d.out_st = fifo_host_pkg::OUT_DROP;
          end else begin
            d.bit_out = next_bit(q.bit_out);
            d.cnt_out = fifo_host_pkg::PULSE_CYC;
            d.out_st = fifo_host_pkg::OUT_SETTLE;
          end
        end
      end
      fifo_host_pkg::OUT_DROP: begin
        if (!s.out_empty_n) begin
          d.rd_valid = 1'h1;
          d.drv.pop_serial_n = 1'h0;
          d.out_st = fifo_host_pkg::OUT_WAIT;
        end
      end
      default: d.out_st = fifo_host_pkg::OUT_WAIT;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      q <= '0;
      q.cnt_in <= fifo_host_pkg::PULSE_CYC;
      // Both slice enables stay low from here on, so the slice is its own row master.
      q.drv <= fifo_host_pkg::DRIVE_RST;
    end else begin
      q <= d;
    end
  end

  assign wr_ready = q.wr_ready;
  assign rd_valid = q.rd_valid;
  assign rd_data = q.rd_data;
  assign pins_out = q.drv;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  AST_LOAD_CLK_LOW: assert property (q.drv.parallel_load |-> !q.drv.ser_in_clk_n)
    else $error("serial input clock high during parallel load");
  AST_SERIAL_NO_LOAD: assert property (
    (q.in_st == fifo_host_pkg::IN_SHIFT_HI || q.in_st == fifo_host_pkg::IN_SHIFT_LO)
      |-> !q.drv.parallel_load)
    else $error("parallel load high during serial entry");
  AST_POP_SERIAL_TIED: assert property (!q.rd_ser |-> !q.drv.pop_serial_n)
    else $error("transfer-out-serial high in parallel mode");
  AST_SOCLK_QUIET: assert property (q.drv.ser_out_clk_n |-> (q.rd_ser && s.out_empty_n))
    else $error("serial output clock high outside serial extraction");
  AST_PUSH_ON_FULL: assert property ($fell(q.drv.push_stack_n) |-> $past(!s.in_full_n))
    else $error("push requested without input full");
  AST_MASTER_SLICE: assert property (!q.drv.in_enable_n && !q.drv.out_enable_n)
    else $error("slice enables not held as row master");
  AST_READ_AFTER_EMPTY: assert property ($rose(q.rd_valid) |-> $past(!s.out_empty_n))
    else $error("read word offered before output empty was seen");

  COV_PAR_WRITE: cover property ($rose(q.drv.parallel_load) ##[1:200] $fell(q.drv.push_stack_n));
  COV_SER_WRITE: cover property ($fell(q.drv.ser_in_clk_n) ##[1:300] $fell(q.drv.push_stack_n));
  COV_SER_READ: cover property (q.rd_ser && $rose(q.drv.ser_out_clk_n) ##[1:400] $rose(q.rd_valid));
endmodule : fifo_host
`default_nettype wire

// ---- hdl/sync2.sv ----
/*
 Two-stage synchroniser for a bundle of levels from outside the clock domain.
 Assumes each bit is a slow level; bits are not kept coherent with each other.
*/
`timescale 1ns/100ps
`default_nettype none
module sync2 #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output wire logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } state_s;

  state_s st_q;
  state_s st_d;

  always_comb begin
    st_d.meta = d;
    st_d.stable = st_q.meta;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign q = st_q.stable;
endmodule : sync2
`default_nettype wire

// ---- inc/fifo_host_pkg.sv ----
/*
 Constants, pin bundles and state enumerations for the controller that drives
 one 4-bit fall-through FIFO slice through its pins. Assumes a 200 MHz system clock.
*/
package fifo_host_pkg;

  localparam int CLK_NS = 5;
  // Shortest high or low time on the load and clear strobes and the serial clocks; the push strobe is not timed.
  localparam int PULSE_NS = 50;
  localparam int PULSE_CYC_I = (PULSE_NS + CLK_NS - 1) / CLK_NS;

  typedef logic [7:0] cnt_t;
  localparam cnt_t PULSE_CYC = cnt_t'(PULSE_CYC_I);
  localparam cnt_t CNT_ZERO = 8'h00;
  localparam cnt_t CNT_ONE = 8'h01;

  localparam int WORD_W = 4;
  typedef logic [WORD_W-1:0] word_t;
  typedef logic [1:0] bit_idx_t;
  localparam bit_idx_t FIRST_BIT = 2'h0;
  localparam bit_idx_t LAST_BIT = 2'h3;
  localparam bit_idx_t BIT_STEP = 2'h1;

  typedef struct packed {
    word_t par_in_bits;
    logic ser_in_bit;
    logic parallel_load;
    logic ser_in_clk_n;
    logic in_enable_n;
    logic push_stack_n;
    logic clear_n;
    logic out_enable_n;
    logic pop_serial_n;
    logic pop_parallel;
    logic par_out_drive_n;
    logic ser_out_clk_n;
  } drive_s;

  typedef struct packed {
    word_t par_out_bits;
    logic ser_out_bit;
    logic in_full_n;
    logic out_empty_n;
  } sense_s;

  localparam int SENSE_W = $bits(sense_s);

  localparam drive_s DRIVE_RST = '{
    par_in_bits: 4'h0,
    ser_in_bit: 1'h0,
    parallel_load: 1'h0,
    ser_in_clk_n: 1'h0,
    in_enable_n: 1'h0,
    push_stack_n: 1'h1,
    clear_n: 1'h0,
    out_enable_n: 1'h0,
    pop_serial_n: 1'h0,
    pop_parallel: 1'h0,
    par_out_drive_n: 1'h1,
    ser_out_clk_n: 1'h0
  };

  typedef enum logic [2:0] {
    IN_CLEAR,
    IN_IDLE,
    IN_PLOAD,
    IN_SHIFT_HI,
    IN_SHIFT_LO,
    IN_PUSH
  } in_st_e;

  typedef enum logic [2:0] {
    OUT_WAIT,
    OUT_REQ,
    OUT_SETTLE,
    OUT_SCLK_HI,
    OUT_SCLK_LO,
    OUT_DROP
  } out_st_e;

endpackage : fifo_host_pkg

// ---- verification/fifo_host_tb.sv ----
/*
 Self-checking bench for the FIFO slice controller against the slice model.
 Assumes the user ports follow the hand-over contract of the controller.
*/
`timescale 1ns/100ps
`default_nettype none
module fifo_host_tb;
  localparam fifo_host_pkg::word_t PAT [4] = '{4'h1, 4'he, 4'hc, 4'h3};
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic wr_valid = 1'b0;
  fifo_host_pkg::word_t wr_data = 4'h0;
  logic wr_serial = 1'b0;
  logic wr_ready;
  logic rd_serial = 1'b0;
  logic rd_ready = 1'b0;
  logic rd_valid;
  fifo_host_pkg::word_t rd_data;
  fifo_host_pkg::sense_s pins_in;
  fifo_host_pkg::drive_s pins_out;
  int bad_count = 0;
  int total_checks = 0;
  int cyc = 0;
  fifo_host fifo_host_inst (.clk_sys(clk_sys), .rst_n(rst_n), .wr_valid(wr_valid),
    .wr_data(wr_data), .wr_serial(wr_serial), .wr_ready(wr_ready), .rd_serial(rd_serial),
    .rd_ready(rd_ready), .rd_valid(rd_valid), .rd_data(rd_data), .pins_in(pins_in),
    .pins_out(pins_out));
  fifo_slice_model fifo_slice_model_inst (.drv(pins_out), .sns(pins_in));
  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [3:0] exp, input logic [3:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic put(input logic ser, input fifo_host_pkg::word_t d);
    int k;
    k = 0;
    while (wr_ready !== 1'b1 && k < 2000) begin
      @(negedge clk_sys);
      k++;
    end
    chk("wr_ready", 4'h1, {3'h0, wr_ready});
    wr_valid = 1'b1;
    wr_serial = ser;
    wr_data = d;
    @(negedge clk_sys);
    wr_valid = 1'b0;
  endtask : put
  // The next read mode is set with rd_ready, since the next request starts then.
  task automatic get(input fifo_host_pkg::word_t exp, input logic nxt_ser);
    int k;
    k = 0;
    while (rd_valid !== 1'b1 && k < 2000) begin
      @(negedge clk_sys);
      k++;
    end
    chk("rd_valid", 4'h1, {3'h0, rd_valid});
    chk("rd_data", exp, rd_data);
    rd_ready = 1'b1;
    rd_serial = nxt_ser;
    @(negedge clk_sys);
    rd_ready = 1'b0;
  endtask : get
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 60000) begin
      bad_count++;
      summarize();
    end
  end
  initial begin
    repeat (16) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (300) @(negedge clk_sys);
    chk("rd_valid", 4'h0, {3'h0, rd_valid});
    for (int i = 0; i < 4; i++) begin
      put(i[0], PAT[i]);
      get(PAT[i], 1'((i + 1) >> 1));
    end
    // Reads are held off so the stack and input register fill completely.
    for (int i = 0; i < 16; i++) begin
      put(1'b0, 4'(i));
    end
    repeat (400) @(negedge clk_sys);
    chk("wr_ready", 4'h0, {3'h0, wr_ready});
    for (int i = 0; i < 16; i++) begin
      get(4'(i), 1'b0);
    end
    repeat (400) @(negedge clk_sys);
    chk("rd_valid", 4'h0, {3'h0, rd_valid});
    chk("wr_ready", 4'h1, {3'h0, wr_ready});
    summarize();
  end
endmodule : fifo_host_tb
`default_nettype wire

// ---- verification/fifo_slice_model.sv ----
/*
 Behavioural model of one fall-through FIFO slice used alone as a row master.
 Assumes the host drives every pin through a drive_s bundle and reads sense_s.
*/
`timescale 1ns/100ps
`default_nettype none
module fifo_slice_model #(
  parameter int FALL_NS = 100,
  parameter int DEPTH = 14
) (
  input wire fifo_host_pkg::drive_s drv,
  output wire fifo_host_pkg::sense_s sns
);
  logic [4:0] inr = 5'h08;
  logic req = 1'b0;
  logic oval = 1'b0;
  logic oser = 1'b0;
  logic took = 1'b0;
  logic mst = 1'b0;
  logic [3:0] oreg = 4'h0;
  logic [2:0] ocnt = 3'h0;
  int n = 0;
  fifo_host_pkg::word_t q[$];
  wire logic top = drv.pop_parallel;
  wire logic sic = drv.ser_in_clk_n;
  wire logic soc = drv.ser_out_clk_n;
  // Released outputs show the inverse so a stale sample never passes.
  assign sns = {drv.par_out_drive_n ? ~oreg : oreg, oser ? oreg[0] : ~oreg[0], ~inr[4], oval};
  // Level inputs are polled; all host pulses last far longer than the poll step.
  always #2 begin
    if (!drv.clear_n) begin
      q.delete();
      n = 0;
      inr = 5'h08;
      req = 1'b0;
      took = 1'b0;
      mst = !drv.in_enable_n;
      oval = 1'b0;
      oser = 1'b0;
    end else begin
      if (drv.parallel_load) begin
        inr = {1'b1, (inr[4] ? inr[3:0] : 4'h0) | drv.par_in_bits};
      end
      if (!drv.push_stack_n && inr[4] && !req && n < DEPTH) begin
        req = 1'b1;
        n++;
        fork
          automatic fifo_host_pkg::word_t w = inr[3:0];
          #(FALL_NS) q.push_back(w);
        join_none
      end
      if (req && !drv.parallel_load && (mst || !drv.in_enable_n)) begin
        inr = 5'h08;
        req = 1'b0;
      end
      if (top && !drv.pop_serial_n && !took && q.size() > 0) begin
        oreg = q.pop_front();
        n--;
        took = 1'b1;
        oval = mst || !drv.out_enable_n;
        oser = 1'b1;
        ocnt = 3'h0;
      end
    end
  end
  always @(negedge top) begin
    took = 1'b0;
    oval = 1'b0;
  end
  always @(negedge sic) begin
    if (!drv.in_enable_n && !inr[4]) begin
      inr = {inr[0], drv.ser_in_bit, inr[3:1]};
    end
  end
  always @(negedge soc) begin
    if (oser) begin
      oreg = {oreg[0], oreg[3:1]};
      ocnt++;
      if (ocnt == 3'h4) begin
        oval = 1'b0;
        oser = 1'b0;
      end
    end
  end
endmodule : fifo_slice_model
`default_nettype wire
